// [design/liu_clock_and_diag_regs.sv]
// Notes on behaviour
// - aux clock driven when enabled and pll on, else tristate
// - family bit picks T1 or E1 master base
// - pll off: master clock used directly
// - multiple field scales expected master clock
// - hitless bit plus low enable drops termination
// - bert select chooses one of eight channels
// - bert active on one channel when enabled, else on none
// - rising insert bit inserts one violation
// - violations latch status, read clears it
// - only first violation in three-period window
// - zeros need enable; code needs hdb3, not disabled
// - dual rail counts only bipolar violations
// - recv invert bit picks data alignment edge
// - sample edge pin forces falling edge
// - pll source field picks recovered clock 1..8
// - pll falls back to master clock on los
// - line rate select: 2.048 set, 1.544 clear
// - aux select field sets aux frequency code
// - los: gate low, or master clock within 10 ms
// - interrupt low when active, idle per bit
// - status clears on read, or write-one if enabled
// - pll kind bit: master or recovered clock
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "liu_clock_and_diag_params.svh"
module liu_clock_and_diag_regs #(
   parameter int CHANNELS     = 8,
   parameter int LOS_SWITCH_CYCLES = (`LOS_SWITCH_MS * (`CLK_SYS_HZ / 1000))
) (
   input  wire logic                          clk_sys,
   input  wire logic                          arst_n,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [9:0]                    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic [CHANNELS-1:0]           line_clk_in,
   input  wire logic [CHANNELS-1:0]           los_in,
   input  wire liu_clock_and_diag_pkg::viol_events_t viol_in,
   input  wire logic                          output_enable_pin,
   input  wire logic                          sample_edge_pin,
   input  wire logic                          irq_active,
   input  wire logic [CHANNELS-1:0]           latched_irq_status,
   output logic [CHANNELS-1:0]                irq_status_clear,
   output logic                               irq_n_o,
   output logic                               irq_n_oe,
   output logic                               aux_clock_oe,
   output logic                               line_rate_clock_oe,
   output liu_clock_and_diag_pkg::clock_cfg_t clock_cfg,
   output logic [CHANNELS-1:0]                pll_ref_line,
   output logic                               pll_ref_master,
   output logic                               termination_off,
   output logic [CHANNELS-1:0]                bert_attach,
   output logic [CHANNELS-1:0]                violation_insert_pulse,
   output logic [CHANNELS-1:0]                recv_falling_edge,
   output logic [CHANNELS-1:0]                xmit_rising_edge,
   output logic [CHANNELS-1:0]                rclk_gate_low,
   output logic [CHANNELS-1:0]                rclk_use_master
);
   initial begin
      if (CHANNELS != 8) $error("channel count must be 8");
      if (LOS_SWITCH_CYCLES < 1) $error("los switch count must be positive");
   end

   logic [7:0] master_clock_reg;
   logic [7:0] global_mgmt_reg;
   logic [7:0] zero_detect_enable_reg;
   logic [7:0] code_check_disable_reg;
   logic [7:0] line_mode_reg;
   logic [7:0] bert_channel_control_reg;
   logic [7:0] violation_insert_reg;
   logic [7:0] line_violation_status_reg;
   logic [7:0] recv_clock_invert_reg;
   logic [7:0] xmit_clock_invert_reg;
   logic [7:0] clock_control_reg;
   logic [7:0] recv_clock_gate_on_los_reg;
   logic [7:0] global_irq_control_reg;
   logic [7:0] rd_data_next;
   logic [7:0] wr_byte;
   logic [7:0] index;
   logic       access;
   logic       wr_en;
   logic       rd_en;
   logic       valid_addr;

   // single-cycle answer: ack one cycle after the request appears
   assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en   = access & wb_we_i & wb_sel_i[0];
   assign rd_en   = access & ~wb_we_i;
   assign index   = wb_adr_i[9:2];
   assign wr_byte = wb_dat_i[7:0];

   always_comb
   begin
      valid_addr = 1'b1;
      rd_data_next = 8'h00;
      if (index == `IDX_MASTER_CLOCK) rd_data_next = master_clock_reg;
      else if (index == `IDX_GLOBAL_MGMT) rd_data_next = global_mgmt_reg;
      else if (index == `IDX_ZERO_DETECT) rd_data_next = zero_detect_enable_reg;
      else if (index == `IDX_CODE_CHECK) rd_data_next = code_check_disable_reg;
      else if (index == `IDX_LINE_MODE) rd_data_next = line_mode_reg;
      else if (index == `IDX_BERT_CHANNEL) rd_data_next = bert_channel_control_reg;
      else if (index == `IDX_VIOLATION_INSERT) rd_data_next = violation_insert_reg;
      else if (index == `IDX_LINE_VIOL_STATUS) rd_data_next = line_violation_status_reg;
      else if (index == `IDX_RECV_CLK_INVERT) rd_data_next = recv_clock_invert_reg;
      else if (index == `IDX_XMIT_CLK_INVERT) rd_data_next = xmit_clock_invert_reg;
      else if (index == `IDX_CLOCK_CONTROL) rd_data_next = clock_control_reg;
      else if (index == `IDX_CLK_GATE_ON_LOS) rd_data_next = recv_clock_gate_on_los_reg;
      else if (index == `IDX_GLOBAL_IRQ_CTRL) rd_data_next = global_irq_control_reg;
      else valid_addr = 1'b0;
   end

   // bus answer; unmapped reads return zero, writes ignored
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= access;
         if (rd_en)
            wb_dat_o <= {24'h00_0000, rd_data_next};
      end
   end

   // plain read/write registers
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         master_clock_reg           <= `REG_RESET;
         global_mgmt_reg            <= `REG_RESET;
         zero_detect_enable_reg     <= `REG_RESET;
         code_check_disable_reg     <= `REG_RESET;
         line_mode_reg              <= `REG_RESET;
         bert_channel_control_reg   <= `REG_RESET;
         violation_insert_reg       <= `REG_RESET;
         recv_clock_invert_reg      <= `REG_RESET;
         xmit_clock_invert_reg      <= `REG_RESET;
         clock_control_reg          <= `REG_RESET;
         recv_clock_gate_on_los_reg <= `REG_RESET;
         global_irq_control_reg     <= `REG_RESET;
      end
      else if (wr_en && valid_addr)
      begin
         if (index == `IDX_MASTER_CLOCK) master_clock_reg <= wr_byte & 8'h7f;
         else if (index == `IDX_GLOBAL_MGMT) global_mgmt_reg <= wr_byte & 8'h01;
         else if (index == `IDX_ZERO_DETECT) zero_detect_enable_reg <= wr_byte;
         else if (index == `IDX_CODE_CHECK) code_check_disable_reg <= wr_byte;
         else if (index == `IDX_LINE_MODE) line_mode_reg <= wr_byte & 8'h03;
         else if (index == `IDX_BERT_CHANNEL) bert_channel_control_reg <= wr_byte & 8'he1;
         else if (index == `IDX_VIOLATION_INSERT) violation_insert_reg <= wr_byte;
         else if (index == `IDX_RECV_CLK_INVERT) recv_clock_invert_reg <= wr_byte;
         else if (index == `IDX_XMIT_CLK_INVERT) xmit_clock_invert_reg <= wr_byte;
         else if (index == `IDX_CLOCK_CONTROL) clock_control_reg <= wr_byte;
         else if (index == `IDX_CLK_GATE_ON_LOS) recv_clock_gate_on_los_reg <= wr_byte;
         else if (index == `IDX_GLOBAL_IRQ_CTRL) global_irq_control_reg <= wr_byte & 8'h03;
      end
   end

   // clock configuration
   logic       pll_on;
   logic [2:0] pll_channel;
   logic       pll_kind_line;
   assign pll_on        = master_clock_reg[`MC_PLL_ENABLE];
   assign pll_kind_line = master_clock_reg[`MC_PLL_KIND];
   assign pll_channel   = clock_control_reg[`CC_PLL_SRC_LO +: 3];

   always_comb
   begin
      clock_cfg.use_pll       = pll_on;
      clock_cfg.family_t1     = master_clock_reg[`MC_FAMILY];
      clock_cfg.multiple      = master_clock_reg[`MC_MULT_LO +: 2];
      clock_cfg.pll_from_line = pll_kind_line;
      clock_cfg.pll_channel   = pll_channel;
      clock_cfg.line_rate_e1  = clock_control_reg[`CC_LINE_RATE_SEL];
      clock_cfg.aux_sel       = clock_control_reg[`CC_AUX_SEL_LO +: 4];
   end

   assign aux_clock_oe       = master_clock_reg[`MC_AUX_ENABLE] & pll_on;
   assign line_rate_clock_oe = master_clock_reg[`MC_LINE_RATE_EN] & pll_on;

   // synchronisers for pins and line signals
   logic [CHANNELS-1:0] los_meta;
   logic [CHANNELS-1:0] los_sync;
   logic [CHANNELS-1:0] lclk_meta;
   logic [CHANNELS-1:0] lclk_sync;
   logic [CHANNELS-1:0] lclk_prev;
   logic [2:0]          pin_meta;
   logic [2:0]          pin_sync;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         los_meta  <= '0;
         los_sync  <= '0;
         lclk_meta <= '0;
         lclk_sync <= '0;
         lclk_prev <= '0;
         pin_meta  <= 3'h0;
         pin_sync  <= 3'h0;
      end
      else
      begin
         los_meta  <= los_in;
         los_sync  <= los_meta;
         lclk_meta <= line_clk_in;
         lclk_sync <= lclk_meta;
         lclk_prev <= lclk_sync;
         pin_meta  <= {irq_active, sample_edge_pin, output_enable_pin};
         pin_sync  <= pin_meta;
      end
   end

   // pll source with fallback to master clock on los
   always_comb
   begin
      pll_ref_line = '0;
      pll_ref_master = 1'b1;
      if (pll_kind_line && !los_sync[pll_channel])
      begin
         pll_ref_line[pll_channel] = 1'b1;
         pll_ref_master = 1'b0;
      end
   end

   assign termination_off = global_mgmt_reg[0] & ~pin_sync[0];

   // violation insert edge detect
   logic [CHANNELS-1:0] insert_prev;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         insert_prev            <= '0;
         violation_insert_pulse <= '0;
      end
      else
      begin
         insert_prev            <= violation_insert_reg;
         violation_insert_pulse <= violation_insert_reg & ~insert_prev;
      end
   end

   // violation qualification, window and status latch
   logic [1:0]          win_cnt [CHANNELS];
   logic                status_read;
   logic                status_write;
   logic                write_clears;
   assign write_clears = global_irq_control_reg[`GI_WRITE_CLEARS];
   assign status_read  = rd_en && index == `IDX_LINE_VIOL_STATUS && !write_clears;
   assign status_write = wr_en && index == `IDX_LINE_VIOL_STATUS && write_clears;

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_chan
         logic dual_rail;
         logic hdb3;
         logic ev;
         logic take;
         logic clr;
         logic lclk_rise;
         assign dual_rail = line_mode_reg[`LM_DUAL_RAIL];
         assign hdb3      = line_mode_reg[`LM_HDB3];
         assign lclk_rise = lclk_sync[ch] & ~lclk_prev[ch];
         assign ev = viol_in.bipolar[ch]
                   | (!dual_rail && hdb3 && !code_check_disable_reg[ch]
                      && viol_in.code[ch])
                   | (!dual_rail && zero_detect_enable_reg[ch]
                      && viol_in.zeros[ch]);
         assign take = ev && win_cnt[ch] == 2'h0;
         assign clr  = status_read | (status_write & wb_dat_i[ch]);

         always_ff @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
               win_cnt[ch] <= 2'h0;
            else if (take)
               win_cnt[ch] <= 2'(`VIOL_WINDOW_PERIODS);
            else if (win_cnt[ch] != 2'h0 && lclk_rise)
               win_cnt[ch] <= win_cnt[ch] - 2'h1;
         end

         // a new violation wins over a clear in the same cycle
         always_ff @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
               line_violation_status_reg[ch] <= 1'b0;
            else if (take)
               line_violation_status_reg[ch] <= 1'b1;
            else if (clr)
               line_violation_status_reg[ch] <= 1'b0;
         end

         assign bert_attach[ch] = bert_channel_control_reg[`BT_ENABLE]
            && bert_channel_control_reg[`BT_SEL_LO +: 3] == 3'(ch);
         assign recv_falling_edge[ch] = recv_clock_invert_reg[ch] | pin_sync[1];
         assign xmit_rising_edge[ch]  = xmit_clock_invert_reg[ch];
         assign rclk_gate_low[ch] = los_sync[ch] & recv_clock_gate_on_los_reg[ch];
      end
   endgenerate

   // los switch-over timer per channel
   logic [31:0] los_cnt [CHANNELS];
   generate
      for (ch = 0; ch < CHANNELS; ch++)
      begin : g_los
         always_ff @(posedge clk_sys or negedge arst_n)
         begin
            if (!arst_n)
            begin
               los_cnt[ch]         <= 32'h0000_0000;
               rclk_use_master[ch] <= 1'b0;
            end
            else if (!los_sync[ch] || recv_clock_gate_on_los_reg[ch])
            begin
               los_cnt[ch]         <= 32'h0000_0000;
               rclk_use_master[ch] <= 1'b0;
            end
            else if (los_cnt[ch] >= 32'(LOS_SWITCH_CYCLES - 1))
               rclk_use_master[ch] <= 1'b1;
            else
               los_cnt[ch] <= los_cnt[ch] + 32'h0000_0001;
         end
      end
   endgenerate

   // interrupt pin: low when active, idle per drive bit
   assign irq_n_o  = ~pin_sync[2];
   assign irq_n_oe = pin_sync[2] | global_irq_control_reg[`GI_IDLE_DRIVE];

   // clear strobes for latched status held in other groups
   assign irq_status_clear = write_clears
      ? ({CHANNELS{wr_en}} & wb_dat_i[CHANNELS-1:0] & latched_irq_status)
      : {CHANNELS{rd_en}};

endmodule // liu_clock_and_diag_regs

// [design/liu_clock_and_diag_params.svh]
`ifndef LIU_CLOCK_AND_DIAG_PARAMS_SVH
`define LIU_CLOCK_AND_DIAG_PARAMS_SVH
// register indices; byte address is four times the index
`define IDX_MASTER_CLOCK      8'h06
`define IDX_GLOBAL_MGMT       8'h07
`define IDX_ZERO_DETECT       8'h08
`define IDX_CODE_CHECK        8'h09
`define IDX_LINE_MODE         8'h0a
`define IDX_BERT_CHANNEL      8'h10
`define IDX_VIOLATION_INSERT  8'h11
`define IDX_LINE_VIOL_STATUS  8'h12
`define IDX_RECV_CLK_INVERT   8'h13
`define IDX_XMIT_CLK_INVERT   8'h14
`define IDX_CLOCK_CONTROL     8'h15
`define IDX_CLK_GATE_ON_LOS   8'h16
`define IDX_GLOBAL_IRQ_CTRL   8'h1e
`define REG_RESET             8'h00
// master clock register fields
`define MC_PLL_ENABLE         0
`define MC_FAMILY             1
`define MC_MULT_LO            2
`define MC_AUX_ENABLE         4
`define MC_LINE_RATE_EN       5
`define MC_PLL_KIND           6
// clock control fields
`define CC_AUX_SEL_LO         0
`define CC_LINE_RATE_SEL      4
`define CC_PLL_SRC_LO         5
// bert control fields
`define BT_ENABLE             0
`define BT_SEL_LO             5
// irq control fields
`define GI_WRITE_CLEARS       0
`define GI_IDLE_DRIVE         1
// line mode fields (own register)
`define LM_DUAL_RAIL          0
`define LM_HDB3               1
// violation capture window in line clock periods
`define VIOL_WINDOW_PERIODS   3
// loss-of-signal switch time to master clock
`define LOS_SWITCH_MS         10
`define CLK_SYS_HZ            40000000
`endif

// [design/liu_clock_and_diag_pkg.sv]
package liu_clock_and_diag_pkg;
   typedef struct packed {
      logic [7:0] bipolar;
      logic [7:0] code;
      logic [7:0] zeros;
   } viol_events_t;
   typedef struct packed {
      logic       use_pll;
      logic       family_t1;
      logic [1:0] multiple;
      logic       pll_from_line;
      logic [2:0] pll_channel;
      logic       line_rate_e1;
      logic [3:0] aux_sel;
   } clock_cfg_t;
endpackage

// [bench/liu_regs_monitor.sv]
`timescale 1ns/1ps
module liu_regs_monitor #(
   parameter int CHANNELS = 8
) (
   input wire logic                               clk_sys,
   input wire logic                               arst_n,
   input wire logic [CHANNELS-1:0]                los_in,
   input wire logic                               output_enable_pin,
   input wire logic                               sample_edge_pin,
   input wire logic                               irq_active,
   input wire logic                               irq_n_o,
   input wire logic                               irq_n_oe,
   input wire logic                               aux_clock_oe,
   input wire liu_clock_and_diag_pkg::clock_cfg_t clock_cfg,
   input wire logic [CHANNELS-1:0]                pll_ref_line,
   input wire logic                               pll_ref_master,
   input wire logic                               termination_off,
   input wire logic [CHANNELS-1:0]                bert_attach,
   input wire logic [CHANNELS-1:0]                violation_insert_pulse,
   input wire logic [CHANNELS-1:0]                recv_falling_edge,
   input wire logic [CHANNELS-1:0]                rclk_gate_low
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   property p_aux; aux_clock_oe |-> clock_cfg.use_pll; endproperty
   a_aux: assert property (p_aux) else $error("aux oe without pll");
   property p_hitless; output_enable_pin [*5] |-> !termination_off; endproperty
   a_hitless: assert property (p_hitless) else $error("termination off while oe high");
   property p_bert; $onehot0(bert_attach); endproperty
   a_bert: assert property (p_bert) else $error("bert on several channels");
   property p_pll_src; $onehot({pll_ref_master, pll_ref_line}); endproperty
   a_pll_src: assert property (p_pll_src) else $error("pll source not single");
   property p_pll_ch; pll_ref_line != '0 |-> pll_ref_line == (CHANNELS'(1) << clock_cfg.pll_channel);
   endproperty
   a_pll_ch: assert property (p_pll_ch) else $error("pll channel mismatch");
   property p_ins; violation_insert_pulse != '0 |=> (violation_insert_pulse & $past(violation_insert_pulse)) == '0;
   endproperty
   a_ins: assert property (p_ins) else $error("insert pulse longer than one");
   property p_sedge; sample_edge_pin [*5] |-> &recv_falling_edge; endproperty
   a_sedge: assert property (p_sedge) else $error("sample edge pin ignored");
   property p_irq; irq_active [*5] |-> irq_n_oe && !irq_n_o; endproperty
   a_irq: assert property (p_irq) else $error("irq pin not driven low");
   property p_gate; (los_in == '0) [*5] |-> rclk_gate_low == '0; endproperty
   a_gate: assert property (p_gate) else $error("clock gated without los");
   c_insert: cover property (violation_insert_pulse != '0);
   c_term: cover property (termination_off);
   c_gate: cover property (rclk_gate_low != '0);
endmodule // liu_regs_monitor
bind liu_clock_and_diag_regs liu_regs_monitor #(.CHANNELS(CHANNELS)) mon (
   .clk_sys(clk_sys), .arst_n(arst_n), .los_in(los_in), .output_enable_pin(output_enable_pin),
   .sample_edge_pin(sample_edge_pin), .irq_active(irq_active), .irq_n_o(irq_n_o),
   .irq_n_oe(irq_n_oe), .aux_clock_oe(aux_clock_oe), .clock_cfg(clock_cfg),
   .pll_ref_line(pll_ref_line), .pll_ref_master(pll_ref_master),
   .termination_off(termination_off), .bert_attach(bert_attach),
   .violation_insert_pulse(violation_insert_pulse), .recv_falling_edge(recv_falling_edge),
   .rclk_gate_low(rclk_gate_low));

// [bench/wb_host_model.sv]
`timescale 1ns/1ps
module wb_host_model (
   input wire logic        clk_sys,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   output logic            wb_cyc_i,
   output logic            wb_stb_i,
   output logic            wb_we_i,
   output logic [9:0]      wb_adr_i,
   output logic [3:0]      wb_sel_i,
   output logic [31:0]     wb_dat_i
);
   initial
   begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 10'h000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
   end
   // one classic cycle; held until ack is sampled high
   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'hf;
      wb_dat_i <= {24'h000000, d};
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_sys);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_adr_i <= ~wb_adr_i;
      wb_dat_i <= ~wb_dat_i;
   endtask
endmodule // wb_host_model

// [bench/liu_clock_and_diag_regs_bench.sv]
`timescale 1ns/1ps
module liu_clock_and_diag_regs_bench;
   logic                                 clk_sys = 1'b0;
   logic                                 arst_n = 1'b0;
   logic                                 wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [9:0]                           wb_adr_i;
   logic [3:0]                           wb_sel_i;
   logic [31:0]                          wb_dat_i, wb_dat_o, q;
   logic [7:0]                           line_clk_in = 8'h00;
   logic [7:0]                           los_in = 8'h00;
   liu_clock_and_diag_pkg::viol_events_t viol_in = '0;
   logic                                 output_enable_pin = 1'b1;
   logic                                 sample_edge_pin = 1'b0;
   logic                                 irq_active = 1'b0;
   logic [7:0]                           latched_irq_status = 8'h00;
   logic                                 irq_n_o, irq_n_oe, aux_clock_oe, line_rate_clock_oe;
   liu_clock_and_diag_pkg::clock_cfg_t   clock_cfg;
   logic [7:0]                           pll_ref_line, bert_attach, violation_insert_pulse;
   logic                                 pll_ref_master, termination_off, e;
   logic [7:0]                           recv_falling_edge, xmit_rising_edge, irq_status_clear;
   logic [7:0]                           rclk_gate_low, rclk_use_master, mc, cc, bt;
   logic [7:0]                           m [0:255];
   logic [7:0]                           regs [13] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1e};
   logic [7:0]                           rw [11] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h10,
      8'h11, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1e};
   logic [7:0]                           mk [11] = '{8'h7f, 8'h01, 8'hff, 8'hff, 8'he1,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03};
   logic [5:0]                           vt [9] = '{6'h00, 6'h28, 6'h2a, 6'h10, 6'h18,
      6'h19, 6'h1c, 6'h2e, 6'h0c};
   int                                   fail_count = 0;
   int                                   n_compared = 0;
   int                                   cycles = 0;
   int                                   pulses = 0;
   int                                   clears = 0;
   int                                   base, ch;
   always #12.5 clk_sys = ~clk_sys;
   always #100 line_clk_in = ~line_clk_in;
   liu_clock_and_diag_regs #(.CHANNELS(8), .LOS_SWITCH_CYCLES(20)) uut (
      .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_clk_in(line_clk_in), .los_in(los_in),
      .viol_in(viol_in), .output_enable_pin(output_enable_pin),
      .sample_edge_pin(sample_edge_pin), .irq_active(irq_active),
      .latched_irq_status(latched_irq_status), .irq_status_clear(irq_status_clear),
      .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .aux_clock_oe(aux_clock_oe),
      .line_rate_clock_oe(line_rate_clock_oe), .clock_cfg(clock_cfg),
      .pll_ref_line(pll_ref_line), .pll_ref_master(pll_ref_master),
      .termination_off(termination_off), .bert_attach(bert_attach),
      .violation_insert_pulse(violation_insert_pulse), .recv_falling_edge(recv_falling_edge),
      .xmit_rising_edge(xmit_rising_edge), .rclk_gate_low(rclk_gate_low),
      .rclk_use_master(rclk_use_master));
   wb_host_model host (.clk_sys(clk_sys), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      pulses <= pulses + $countones(violation_insert_pulse);
      clears <= clears + $countones(irq_status_clear);
      if (cycles == 20000)
      begin
         fail_count++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.bus(1'b1, a, d, q);
      m[a] = d;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host.bus(1'b0, a, 8'h00, q);
      chk(q, {24'h000000, exp});
   endtask
   // one-cycle violation event of kind k (0 bipolar, 1 code, 2 zeros)
   task automatic ev(input int k, input int c, input int w);
      @(posedge clk_sys);
      viol_in <= 24'h000001 << (c + 8 * (2 - k));
      @(posedge clk_sys);
      viol_in <= '0;
      repeat (w) @(posedge clk_sys);
   endtask
   initial
   begin
      void'($urandom(89));
      repeat (6) @(posedge clk_sys);
      arst_n <= 1'b1;
      latched_irq_status <= 8'($urandom);
      foreach (regs[i]) rd(regs[i], 8'h00);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      repeat (6)
      begin
         foreach (rw[i]) wr(rw[i], 8'($urandom) & mk[i]);
         foreach (rw[i]) rd(rw[i], m[rw[i]]);
         mc = m[8'h06];
         cc = m[8'h15];
         bt = m[8'h10];
         chk({clock_cfg, aux_clock_oe, line_rate_clock_oe, bert_attach, pll_ref_line,
              pll_ref_master}, {mc[0], mc[1], mc[3:2], mc[6], cc[7:5], cc[4], cc[3:0],
              mc[4] & mc[0], mc[5] & mc[0], bt[0] ? 8'h01 << bt[7:5] : 8'h00,
              mc[6] ? 8'h01 << cc[7:5] : 8'h00,
              !mc[6]});
         chk({recv_falling_edge, xmit_rising_edge}, {m[8'h13], m[8'h14]});
      end
      foreach (rw[i]) wr(rw[i], 8'h00);
      base = pulses;
      wr(8'h11, 8'h81);
      wr(8'h11, 8'h81);
      wr(8'h11, 8'h00);
      wr(8'h11, 8'h83);
      repeat (3) @(posedge clk_sys);
      chk(pulses - base, 5);
      foreach (vt[i])
      begin
         ch = $urandom_range(7);
         e = vt[i][5:4] == 0 || (!vt[i][2] && (vt[i][5:4] == 1 ? vt[i][3] && !vt[i][0] : vt[i][1]));
         wr(8'h08, {8{vt[i][1]}});
         wr(8'h09, {8{vt[i][0]}});
         wr(8'h0a, {6'h00, vt[i][3:2]});
         ev(vt[i][5:4], ch, 48);
         rd(8'h12, {7'h00, e} << ch);
      end
      ev(0, 1, 0);
      rd(8'h12, 8'h02);
      ev(0, 1, 48);
      rd(8'h12, 8'h00);
      ev(0, 1, 48);
      rd(8'h12, 8'h02);
      wr(8'h1e, 8'h01);
      base = clears;
      ev(0, 5, 48);
      rd(8'h12, 8'h20);
      rd(8'h12, 8'h20);
      wr(8'h12, 8'h20);
      rd(8'h12, 8'h00);
      chk(clears - base, latched_irq_status[5]);
      wr(8'h1e, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk(irq_n_oe, 1'b0);
      wr(8'h1e, 8'h02);
      repeat (2) @(posedge clk_sys);
      chk({irq_n_oe, irq_n_o}, 2'b11);
      irq_active <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk({irq_n_oe, irq_n_o}, 2'b10);
      irq_active <= 1'b0;
      wr(8'h07, 8'h01);
      output_enable_pin <= 1'b0;
      sample_edge_pin <= 1'b1;
      repeat (5) @(posedge clk_sys);
      chk({termination_off, recv_falling_edge}, 9'h1ff);
      output_enable_pin <= 1'b1;
      sample_edge_pin <= 1'b0;
      repeat (5) @(posedge clk_sys);
      chk({termination_off, recv_falling_edge}, 9'h000);
      wr(8'h06, 8'h40);
      wr(8'h15, 8'h60);
      wr(8'h16, 8'h01);
      los_in <= 8'h0b;
      repeat (40) @(posedge clk_sys);
      chk({pll_ref_master, pll_ref_line, rclk_gate_low, rclk_use_master[1]},
          {1'b1, 8'h00, 8'h01, 1'b1});
      los_in <= 8'h00;
      repeat (5) @(posedge clk_sys);
      chk({pll_ref_master, pll_ref_line, rclk_gate_low}, {1'b0, 8'h08, 8'h00});
      test_done;
   end
endmodule // liu_clock_and_diag_regs_bench
